// ---- ops_regs.svh ----
// What this block does
// - supply undervoltage: fault, drive off, hiccup, restart
// - soft-start rises 0 to 1 V in 4 ms
// - modulation level is min(soft-start, skip ramp, feedback/3)
// - oscillator sets drive each period unless blocked
// - current-sense trip drives output low
// - drive forced low at 80% duty limit
// - modulation level clamped to 1 V
// - compensation ramp restarts each period, full swing
// - frequency swept linearly +/-7.5% over 6 ms
// - feedback/3 above 1 V: error flag, timer
// - feedback recovers: timer cleared, error cleared
// - open feedback past 130 ms: drive off, hiccup
// - hiccup done: restart with fresh soft-start
// - feedback below skip threshold suppresses pulses
// - feedback back above threshold resumes pulses
// - skip exit ramps duty over 300 us
// - skip exit above 2.85 V bypasses ramp
// - latch input over 13 us: latched off
// - hiccup cycles supply twice before restart
`ifndef OPS_REGS_SVH
`define OPS_REGS_SVH

// clock
`define OPS_CLK_NS 10
// levels in millivolts
`define OPS_FULL_MV 12'h3E8
`define OPS_FULL_LVL 10'h3E8
`define OPS_FULL_STEPS 1000
`define OPS_FB_DIV 12'h003
`define OPS_STEP_MV 12'hB22
// soft-start and skip recovery times, least times rounded up
`define OPS_SS_TIME_US 4000
`define OPS_SS_CYC ((`OPS_SS_TIME_US * 1000 + `OPS_CLK_NS - 1) / `OPS_CLK_NS)
`define OPS_SKR_TIME_US 300
`define OPS_SKR_CYC ((`OPS_SKR_TIME_US * 1000 + `OPS_CLK_NS - 1) / `OPS_CLK_NS)
// open feedback timeout
`define OPS_FBTO_TIME_MS 130
`define OPS_FBTO_CYC ((`OPS_FBTO_TIME_MS * 1000000) / `OPS_CLK_NS)
// latch input noise filter
`define OPS_LATCH_TIME_NS 13000
`define OPS_LATCH_CYC ((`OPS_LATCH_TIME_NS + `OPS_CLK_NS - 1) / `OPS_CLK_NS)
// oscillator, duty limit, compensation ramp
`define OPS_FSW_KHZ 65
`define OPS_PERIOD_NOM (1000000 / (`OPS_FSW_KHZ * `OPS_CLK_NS))
`define OPS_DMAX_PCT 80
`define OPS_PCT_FULL 100
`define OPS_RAMP_SWING 7'h64
// jitter: span in per-mille of the period, sweep time
`define OPS_JIT_PERMIL 75
`define OPS_JIT_SPAN ((`OPS_PERIOD_NOM * `OPS_JIT_PERMIL) / 1000)
`define OPS_JIT_TIME_US 6000
`define OPS_JIT_TICK ((`OPS_JIT_TIME_US * 1000 / `OPS_CLK_NS) / (4 * `OPS_JIT_SPAN))
// number of supply discharge/charge cycles per hiccup
`define OPS_HIC_CYCLES 2'h2

`endif

// ---- ops_pkg.sv ----
package ops_pkg;
   typedef logic [11:0] ops_mv_t;
   typedef logic [9:0] ops_lvl_t;
   typedef logic [10:0] ops_cyc_t;
   typedef enum logic [1:0] {ST_CHARGE, ST_FALL, ST_RUN, ST_LATCHED} ops_state_e;
endpackage

// ---- ops_sync.sv ----
`timescale 1ns/100ps
module ops_sync #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // two flops; only the second stage is visible outside
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule

// ---- ops_ramp.sv ----
`timescale 1ns/100ps
`include "ops_regs.svh"
module ops_ramp #(
   parameter int STEP_CYC = 400
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic restart,
   input wire logic fill,
   output ops_pkg::ops_lvl_t level
);
   import ops_pkg::*;

   logic [15:0] pre_q;
   ops_lvl_t level_q;
   wire at_full = (level_q >= `OPS_FULL_LVL);
   wire tick = (pre_q == 16'(STEP_CYC - 1));

   // one millivolt per step; fill beats restart so a bypass is never lost
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pre_q <= 16'h0000;
         level_q <= 10'h000;
      end else if (fill) begin
         pre_q <= 16'h0000;
         level_q <= `OPS_FULL_LVL;
      end else if (restart) begin
         pre_q <= 16'h0000;
         level_q <= 10'h000;
      end else begin
         pre_q <= tick ? 16'h0000 : pre_q + 16'h0001;
         if (tick && !at_full) begin
            level_q <= level_q + 10'h001;
         end
      end
   end

   assign level = level_q;
endmodule

// ---- ops_sequencer.sv ----
`timescale 1ns/100ps
`include "ops_regs.svh"
module ops_sequencer #(
   parameter int SS_CYC = `OPS_SS_CYC,
   parameter int SKR_CYC = `OPS_SKR_CYC,
   parameter int FBTO_CYC = `OPS_FBTO_CYC
) (
   input wire logic mclk,
   input wire logic reset,
   input wire ops_pkg::ops_mv_t regulation_feedback,
   input wire ops_pkg::ops_mv_t skip_threshold,
   input wire logic cs_trip_a,
   input wire logic vcc_uvlo_a,
   input wire logic vcc_latch_lvl_a,
   input wire logic vcc_on_lvl_a,
   input wire logic latch_pin_a,
   input wire logic vcc_reset_a,
   output logic gate_drive,
   output ops_pkg::ops_lvl_t modulation_level,
   output logic [6:0] slope_comp_ramp,
   output logic startup_on,
   output logic fb_error,
   output logic fault_active,
   output logic latched_off,
   output logic skipping,
   output logic load_step_detector
);
   import ops_pkg::*;

   // feedback divided down to the soft-start scale
   function automatic ops_mv_t div3(input ops_mv_t v);
      div3 = v / `OPS_FB_DIV;
   endfunction

   function automatic ops_lvl_t lvl_min(input ops_lvl_t a, input ops_lvl_t b);
      lvl_min = (a < b) ? a : b;
   endfunction

   // on-time limit for a given period length
   function automatic ops_cyc_t dmax(input ops_cyc_t len);
      logic [17:0] p;
      p = 18'(len) * 18'(`OPS_DMAX_PCT);
      dmax = ops_cyc_t'(p / 18'(`OPS_PCT_FULL));
   endfunction

   // comparator inputs
   logic [5:0] cmp_s;
   logic cs_trip_s;
   logic uvlo_s;
   logic vcc_latch_s;
   logic vcc_on_s;
   logic latch_pin_s;
   logic vcc_reset_s;

   // state
   ops_state_e state_q, state_d;
   logic [1:0] hic_q, hic_d;
   logic lchg_q, lchg_d;
   logic startup_q;
   logic fault_q;

   // oscillator and jitter
   ops_cyc_t per_cnt_q;
   ops_cyc_t per_len_q;
   logic [7:0] pos_q;
   logic up_q;
   logic [10:0] jt_q;

   // drive path
   logic drive_q;
   ops_cyc_t acc_q;
   logic [6:0] ramp_q;
   ops_lvl_t mod_q;

   // skip, feedback timer, latch filter
   logic skip_q;
   logic step_q;
   logic [23:0] fbt_q;
   logic fb_err_q;
   logic [10:0] lat_cnt_q;

   ops_lvl_t ss_level;
   ops_lvl_t skr_level;

   // analog comparators cross into mclk first
   // comparator synchronisation
   ops_sync #(
      .W(6)
   ) u_sync (
      .mclk(mclk),
      .reset(reset),
      .async_in({vcc_reset_a, latch_pin_a, vcc_on_lvl_a, vcc_latch_lvl_a, vcc_uvlo_a, cs_trip_a}),
      .sync_out(cmp_s)
   );

   assign cs_trip_s = cmp_s[0];
   assign uvlo_s = cmp_s[1];
   assign vcc_latch_s = cmp_s[2];
   assign vcc_on_s = cmp_s[3];
   assign latch_pin_s = cmp_s[4];
   assign vcc_reset_s = cmp_s[5];

   // feedback decode
   wire ops_mv_t fb3 = div3(regulation_feedback);
   wire fb_open = (fb3 > `OPS_FULL_MV);
   wire skip_cond = (regulation_feedback < skip_threshold);
   wire above_step = (regulation_feedback > `OPS_STEP_MV);
   wire running = (state_q == ST_RUN);

   // feedback term limited to full scale
   // one volt clamp
   wire ops_lvl_t fb_lvl = fb_open ? `OPS_FULL_LVL : fb3[9:0];

   // skip exit and load step events
   wire skip_exit = running && skip_q && !skip_cond;
   wire step_evt = skip_exit && above_step;

   // fault timer and latch filter terminal counts
   // open loop timeout
   wire fb_timeout = (fbt_q == 24'(FBTO_CYC - 1));
   wire latch_hit = (lat_cnt_q == 11'(`OPS_LATCH_CYC - 1)) && latch_pin_s;

   // ramps: soft-start held at zero until the run state begins
   // soft-start from zero
   ops_ramp #(
      .STEP_CYC(SS_CYC / `OPS_FULL_STEPS)
   ) u_ss (
      .mclk(mclk),
      .reset(reset),
      .restart(!running),
      .fill(1'b0),
      .level(ss_level)
   );

   // skip recovery: zero while skipping, full outside run or on load step
   // short skip ramp
   ops_ramp #(
      .STEP_CYC(SKR_CYC / `OPS_FULL_STEPS)
   ) u_skr (
      .mclk(mclk),
      .reset(reset),
      .restart(skip_q),
      .fill(!running || step_evt),
      .level(skr_level)
   );

   // modulation level picks the lowest limit
   // lesser of limits
   wire ops_lvl_t mod_d = lvl_min(lvl_min(ss_level, skr_level), fb_lvl);

   // oscillator period with triangular jitter position
   wire period_end = (per_cnt_q == per_len_q - 11'h001);
   wire ops_cyc_t per_len_d = ops_cyc_t'(`OPS_PERIOD_NOM - `OPS_JIT_SPAN) + {3'h0, pos_q};
   wire jit_tick = (jt_q == 11'(`OPS_JIT_TICK - 1));
   wire pos_top = (pos_q == 8'(2 * `OPS_JIT_SPAN));
   wire pos_bot = (pos_q == 8'h00);

   // duty limit from the current period length
   wire ops_cyc_t ton_max = dmax(per_len_q);
   wire duty_ok = ((per_cnt_q + 11'h001) < ton_max);

   // compensation ramp accumulator, spread over ton_max cycles
   wire ops_cyc_t acc_sum = acc_q + ops_cyc_t'(`OPS_RAMP_SWING);
   wire ramp_step = (acc_sum >= ton_max);
   wire ramp_full = (ramp_q >= `OPS_RAMP_SWING);

   // pulses allowed only while running and not skipping
   // skip blocks pulses
   wire pulse_ok = running && !skip_q && !skip_cond;
   wire drive_set = period_end && pulse_ok;
   wire drive_hold = drive_q && pulse_ok && !cs_trip_s && duty_ok;
   wire drive_d = drive_set || drive_hold;

   // supply sequencer next state
   always_comb begin
      state_d = state_q;
      hic_d = hic_q;
      lchg_d = lchg_q;
      unique case (state_q)
         ST_RUN: begin
            if (latch_hit) begin
               state_d = ST_LATCHED;
               lchg_d = 1'b0;
            end else if (uvlo_s || fb_timeout) begin
               state_d = ST_FALL;
               hic_d = 2'h0;
            end
         end
         ST_FALL: begin
            if (latch_hit) begin
               state_d = ST_LATCHED;
               lchg_d = 1'b0;
            end else if (vcc_latch_s) begin
               state_d = ST_CHARGE;
            end
         end
         ST_CHARGE: begin
            if (latch_hit) begin
               state_d = ST_LATCHED;
               lchg_d = 1'b0;
            end else if (vcc_on_s) begin
               if (hic_q == `OPS_HIC_CYCLES - 2'h1) begin
                  state_d = ST_RUN;
                  hic_d = 2'h0;
               end else begin
                  state_d = ST_FALL;
                  hic_d = hic_q + 2'h1;
               end
            end
         end
         ST_LATCHED: begin
            // supply keeps cycling in latch-off; only a deep supply drop frees it
            if (vcc_reset_s) begin
               state_d = ST_CHARGE;
               hic_d = `OPS_HIC_CYCLES - 2'h1;
            end else if (vcc_latch_s) begin
               lchg_d = 1'b1;
            end else if (vcc_on_s) begin
               lchg_d = 1'b0;
            end
         end
      endcase
   end

   wire startup_d = (state_d == ST_CHARGE) || ((state_d == ST_LATCHED) && lchg_d);
   wire fault_d = (state_d == ST_FALL) || (state_d == ST_CHARGE);

   // sequencer registers; power-up begins with the start-up charge
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_q <= ST_CHARGE;
         hic_q <= `OPS_HIC_CYCLES - 2'h1;
         lchg_q <= 1'b0;
         startup_q <= 1'b1;
         fault_q <= 1'b0;
      end else begin
         state_q <= state_d;
         hic_q <= hic_d;
         lchg_q <= lchg_d;
         startup_q <= startup_d;
         fault_q <= fault_d;
      end
   end

   // oscillator; the new length is taken only at a period boundary
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         per_cnt_q <= 11'h000;
         per_len_q <= ops_cyc_t'(`OPS_PERIOD_NOM);
      end else if (period_end) begin
         per_cnt_q <= 11'h000;
         per_len_q <= per_len_d;
      end else begin
         per_cnt_q <= per_cnt_q + 11'h001;
      end
   end

   // jitter sweep runs on wall time, so sweep period is fixed
   // linear triangle sweep
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         jt_q <= 11'h000;
         pos_q <= 8'(`OPS_JIT_SPAN);
         up_q <= 1'b1;
      end else begin
         jt_q <= jit_tick ? 11'h000 : jt_q + 11'h001;
         if (jit_tick) begin
            if (up_q && pos_top) begin
               up_q <= 1'b0;
               pos_q <= pos_q - 8'h01;
            end else if (!up_q && pos_bot) begin
               up_q <= 1'b1;
               pos_q <= pos_q + 8'h01;
            end else begin
               pos_q <= up_q ? pos_q + 8'h01 : pos_q - 8'h01;
            end
         end
      end
   end

   // compensation ramp restarts with each period
   // synchronised slope ramp
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         acc_q <= 11'h000;
         ramp_q <= 7'h00;
      end else if (period_end) begin
         acc_q <= 11'h000;
         ramp_q <= 7'h00;
      end else if (ramp_step && !ramp_full) begin
         acc_q <= acc_sum - ton_max;
         ramp_q <= ramp_q + 7'h01;
      end else if (!ramp_full) begin
         acc_q <= acc_sum;
      end
   end

   // drive latch and modulation level
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         drive_q <= 1'b0;
         mod_q <= 10'h000;
      end else begin
         drive_q <= drive_d;
         mod_q <= mod_d;
      end
   end

   // skip follows feedback directly; exit resumes pulses at next period
   // resume after skip
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         skip_q <= 1'b0;
         step_q <= 1'b0;
      end else begin
         skip_q <= running && skip_cond;
         step_q <= step_evt;
      end
   end

   // open feedback timer counts only while running with feedback high
   // error flag and timer
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         fbt_q <= 24'h000000;
         fb_err_q <= 1'b0;
      end else begin
         fb_err_q <= running && fb_open;
         if (running && fb_open && !fb_timeout) begin
            fbt_q <= fbt_q + 24'h000001;
         end else begin
            fbt_q <= 24'h000000;
         end
      end
   end

   // latch input must stay high for the whole filter window
   // noise filter count
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         lat_cnt_q <= 11'h000;
      end else if (!latch_pin_s || state_q == ST_LATCHED) begin
         lat_cnt_q <= 11'h000;
      end else if (!latch_hit) begin
         lat_cnt_q <= lat_cnt_q + 11'h001;
      end
   end

   // outputs
   assign gate_drive = drive_q;
   assign modulation_level = mod_q;
   assign slope_comp_ramp = ramp_q;
   assign startup_on = startup_q;
   assign fb_error = fb_err_q;
   assign fault_active = fault_q;
   assign latched_off = (state_q == ST_LATCHED);
   assign skipping = skip_q;
   assign load_step_detector = step_q;
endmodule

// ---- ops_sequencer_sva.sv ----
`timescale 1ns/100ps
module ops_sequencer_sva #(
   parameter int FBTO_CYC = 5000
) (
   input wire logic mclk,
   input wire logic reset,
   input wire ops_pkg::ops_mv_t regulation_feedback,
   input wire ops_pkg::ops_mv_t skip_threshold,
   input wire logic cs_trip_a,
   input wire logic latch_pin_a,
   input wire logic vcc_reset_a,
   input wire logic gate_drive,
   input wire ops_pkg::ops_lvl_t modulation_level,
   input wire logic fb_error,
   input wire logic fault_active,
   input wire logic latched_off,
   input wire logic load_step_detector
);
   import ops_pkg::*;
   int hi_cnt;
   int lp_cnt;
   int fe_cnt;
   // run lengths; saturating is not needed, a run never nears int range
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         hi_cnt <= 0;
         lp_cnt <= 0;
         fe_cnt <= 0;
      end else begin
         hi_cnt <= gate_drive ? hi_cnt + 1 : 0;
         lp_cnt <= latch_pin_a ? lp_cnt + 1 : 0;
         fe_cnt <= fb_error ? fe_cnt + 1 : 0;
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   fault_drive_a: assert property (fault_active && $past(fault_active) |-> !gate_drive)
      else $error("drive high during fault");
   level_clamp_a: assert property (modulation_level <= 10'h3E8)
      else $error("modulation level above clamp");
   level_min_a: assert property ($stable(regulation_feedback) [*3]
      |-> modulation_level <= regulation_feedback / 12'h003)
      else $error("modulation level above feedback third");
   skip_block_a: assert property ($past(regulation_feedback < skip_threshold)
      |-> !gate_drive)
      else $error("pulse while below skip level");
   // sense trip is seen through two flops, so the drive must be down two cycles on
   trip_off_a: assert property (cs_trip_a [*3]
      |-> ##2 !(gate_drive && $past(gate_drive)))
      else $error("drive held through current trip");
   duty_limit_a: assert property (hi_cnt <= 1322)
      else $error("on-time beyond duty limit");
   latch_hold_a: assert property (!vcc_reset_a [*4] ##0 latched_off |=> latched_off)
      else $error("latch released without supply reset");
   latch_entry_a: assert property (lp_cnt >= 1310 |-> latched_off)
      else $error("latch input ignored");
   fb_timeout_a: assert property (fe_cnt <= FBTO_CYC + 4)
      else $error("open feedback outlived timer");
   step_pulse_a: assert property (load_step_detector |=> !load_step_detector)
      else $error("load step flag longer than one cycle");
endmodule
bind ops_sequencer ops_sequencer_sva #(.FBTO_CYC(FBTO_CYC)) sva_u (
   .mclk(mclk), .reset(reset), .regulation_feedback(regulation_feedback),
   .skip_threshold(skip_threshold), .cs_trip_a(cs_trip_a), .latch_pin_a(latch_pin_a),
   .vcc_reset_a(vcc_reset_a), .gate_drive(gate_drive), .modulation_level(modulation_level),
   .fb_error(fb_error), .fault_active(fault_active), .latched_off(latched_off),
   .load_step_detector(load_step_detector)
);

// ---- ops_power_model.sv ----
`timescale 1ns/100ps
module ops_power_model (
   input wire logic mclk,
   input wire logic gate_drive,
   input wire ops_pkg::ops_lvl_t modulation_level,
   input wire logic startup_on,
   input wire logic aux_en,
   input wire logic unplug,
   input wire logic sense_dead,
   output logic cs_trip_a,
   output logic vcc_uvlo_a,
   output logic vcc_latch_lvl_a,
   output logic vcc_on_lvl_a,
   output logic vcc_reset_a
);
   import ops_pkg::*;
   int cur_mv = 0;
   int vcc_mv = 0;
   int idle = 0;
   // switch current restarts at zero each pulse; aux winding feeds while switching and for 4000 idle cycles after
   always @(posedge mclk) begin
      cur_mv <= gate_drive ? cur_mv + 1 : 0;
      idle <= gate_drive ? 0 : idle + 1;
      if (unplug)
         vcc_mv <= (vcc_mv < 20) ? 0 : vcc_mv - 20;
      else if (startup_on)
         vcc_mv <= vcc_mv + 10;
      else if (!aux_en || idle > 4000)
         vcc_mv <= vcc_mv - 2;
   end
   // comparators in mV; sense output is low whenever the switch is off
   assign cs_trip_a = gate_drive && !sense_dead && cur_mv >= int'(modulation_level);
   assign vcc_uvlo_a = vcc_mv < 9100;
   assign vcc_latch_lvl_a = vcc_mv <= 5800;
   assign vcc_on_lvl_a = vcc_mv >= 12600;
   assign vcc_reset_a = vcc_mv < 4000;
endmodule

// ---- test_offline_pwm_sequencer.sv ----
`timescale 1ns/100ps
module test_offline_pwm_sequencer;
   import ops_pkg::*;
   localparam int FBTO = 5000;
   logic mclk, reset, lpin, aux_en, unplug, dead, trip, uvlo, lowv, onv, rstv;
   logic gate, st_on, fb_err, fault, latched, skipping, step_seen;
   logic [6:0] ramp;
   ops_mv_t fb, thr;
   ops_lvl_t lvl;
   int errors = 0;
   int comparisons = 0;
   int t, ups, hi;
   ops_sequencer #(.SS_CYC(4000), .SKR_CYC(2000), .FBTO_CYC(FBTO)) dut_u (
      .mclk(mclk), .reset(reset), .regulation_feedback(fb), .skip_threshold(thr),
      .cs_trip_a(trip), .vcc_uvlo_a(uvlo), .vcc_latch_lvl_a(lowv), .vcc_on_lvl_a(onv),
      .latch_pin_a(lpin), .vcc_reset_a(rstv), .gate_drive(gate), .modulation_level(lvl),
      .slope_comp_ramp(ramp), .startup_on(st_on), .fb_error(fb_err), .fault_active(fault),
      .latched_off(latched), .skipping(skipping), .load_step_detector(step_seen));
   ops_power_model pm_u (.mclk(mclk), .gate_drive(gate), .modulation_level(lvl),
      .startup_on(st_on), .aux_en(aux_en), .unplug(unplug), .sense_dead(dead),
      .cs_trip_a(trip), .vcc_uvlo_a(uvlo), .vcc_latch_lvl_a(lowv), .vcc_on_lvl_a(onv),
      .vcc_reset_a(rstv));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // wait for a turn-on edge, counting startup recharges on the way
   task automatic wait_on(input int lim);
      logic pg, ps;
      pg = gate;
      t = 0;
      while (!(gate === 1'b1 && pg === 1'b0) && t < lim) begin
         pg = gate;
         ps = st_on;
         cyc(1);
         t++;
         ups += (st_on === 1'b1 && ps === 1'b0);
      end
   endtask
   task automatic width;
      hi = 0;
      while (gate === 1'b1 && hi < 2000) begin
         cyc(1);
         hi++;
      end
   endtask
   task automatic t_start;
      wait_on(4000);
      chk("first turn-on", t < 4000, 1);
      chk("early level low", lvl < 10'h1F4, 1);
      wait_on(2000);
      chk("period in band", t > 1420 && t < 1656, 1);
      cyc(4500);
      wait_on(2000);
      chk("level is fb third", lvl, 12'hA8C / 3);
      width();
      chk("trip width", hi > 899 && hi < 911, 1);
      $display("start test done");
   endtask
   task automatic t_duty;
      dead = 1'b1;
      wait_on(2000);
      chk("ramp restart", ramp, 0);
      width();
      chk("duty limit width", hi > 1137 && hi < 1323, 1);
      chk("ramp full swing", ramp, 7'h64);
      dead = 1'b0;
      $display("duty test done");
   endtask
   task automatic t_fb;
      fb = 12'hCE4;
      cyc(4);
      chk("error flag", fb_err, 1);
      chk("level clamp", lvl, 10'h3E8);
      cyc(1000);
      fb = 12'hA8C;
      cyc(4);
      chk("error cleared", {fb_err, fault}, 0);
      fb = 12'hCE4;
      cyc(FBTO - 20);
      chk("timer restarted", fault, 0);
      cyc(30);
      chk("timeout fault", {fault, gate}, 2);
      fb = 12'hA8C;
      ups = 0;
      wait_on(20000);
      chk("two recharges", ups, 2);
      chk("soft restart", t < 20000 && lvl < 10'h1F4, 1);
      $display("feedback test done");
   endtask
   task automatic t_uvlo;
      aux_en = 1'b0;
      cyc(1900);
      chk("supply fault", {fault, gate}, 2);
      aux_en = 1'b1;
      wait_on(20000);
      chk("restart", t < 20000, 1);
      $display("supply test done");
   endtask
   task automatic t_skip;
      fb = 12'h3E8;
      cyc(3);
      chk("skip flag", skipping, 1);
      wait_on(3000);
      chk("no pulses", t, 3000);
      fb = 12'hA8C;
      wait_on(2000);
      chk("pulses resume", t < 2000, 1);
      chk("skip ramp", lvl <= t / 2 + 4, 1);
      fb = 12'h3E8;
      cyc(100);
      fb = 12'hB54;
      hi = 0;
      repeat (6) begin
         cyc(1);
         hi += step_seen;
      end
      chk("load step pulse", hi, 1);
      wait_on(2000);
      chk("full level", lvl, 12'hB54 / 3);
      $display("skip test done");
   endtask
   task automatic t_latch;
      lpin = 1'b1;
      cyc(1310);
      chk("latched", {latched, gate}, 2);
      lpin = 1'b0;
      cyc(2000);
      chk("latch holds", latched, 1);
      unplug = 1'b1;
      cyc(800);
      chk("supply reset clears", latched, 0);
      unplug = 1'b0;
      wait_on(5000);
      chk("restart after reset", t < 5000 && lvl < 10'h1F4, 1);
      $display("latch test done");
   endtask
   task automatic wrap_up;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      reset = 1'b1;
      fb = 12'hA8C;
      thr = 12'h4B0;
      lpin = 1'b0;
      aux_en = 1'b1;
      unplug = 1'b0;
      dead = 1'b0;
      repeat (8) @(posedge mclk);
      #1;
      chk("reset outputs", {gate, st_on, fault, latched}, 4'h4);
      reset = 1'b0;
      t_start();
      t_duty();
      t_fb();
      t_uvlo();
      t_skip();
      t_latch();
      wrap_up();
   end
   // watchdog: the sequence needs about 53000 clocks
   initial begin
      repeat (95000) @(posedge mclk);
      errors++;
      wrap_up();
   end
endmodule
